// ### rtl/palette_and_display_power_ctrl.sv
// Colour palette with host port, pixel and panel output, and display power management.
// Assumes pixel, panel data and video memory requests come from logic on core_clk;
// the two activity clocks arrive on pins and are synchronised here.
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

// What this block does
// (R1) Host loads index, then red, green, blue
// (R2) Blue stores entry, then index auto-increments
// (R3) Reads same sequence from separate read index
// (R4) Index write abandons partial sequence, restarts
// (R5) Palette is 256 entries of 6-bit RGB
// (R6) Four-bit pixel indexes the palette
// (R7) Screen regions and cursor drive sync, blank, enable
// (R8) Upper and lower 4-bit panel buses together
// (R9) Pixel mask applied before lookup, immediately
// (R10) Eight-bit host port, decoupled from pixel timing
// (R11) Frame modulation gives 16 greys or 256 colours
// (R12) Normal: panel powered, refresh, CPU access
// (R13) Standby: panel off, refresh kept, access kept
// (R14) Standby exits on activity after sequencing
// (R15) Timeout 1 to 63 minutes forces standby
// (R16) Activity or memory access restarts timer
// (R17) Suspend: panel off, synth off, access refused
// (R18) Suspend refresh: CAS low, RAS on slow edges
// (R19) Software alone enters and leaves suspend
// (R20) Every register reads back its value, except in suspend, where only the extension pair reads back
// (R21) Mirror palette writes to a second table
// (R22) Extension registers via index then data
// (R23) Minute counter from divided clock versus limit
module palette_and_display_power_ctrl #(
  parameter int unsigned CYC_PER_SEC = 125000000
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // Avalon-MM register slave
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // Host video memory path
  input  wire logic                vmem_req,
  output logic                     vmem_gnt,
  // Pixel and panel data from the fetch logic
  input  wire logic [3:0]          pixel_idx,
  input  wire logic [3:0]          fa_data,
  input  wire logic [3:0]          vm_data,
  // Asynchronous pins
  input  wire logic                sleep_activity_clock,
  input  wire logic                slow_refresh_clk,
  // Display outputs
  output palette_pwr_pkg::rgb_t    rgb_out,
  output palette_pwr_pkg::scan_t   scan_out,
  output logic [3:0]               lcd_upper,
  output logic [3:0]               lcd_lower,
  output logic [2:0]               lcd_frc,
  // Second palette
  output palette_pwr_pkg::mirror_t pal_mirror,
  // Power and DRAM control
  output logic                     panel_pwr_on,
  output logic                     synth_pwr_on,
  output logic                     dram_ras_n,
  output logic                     dram_cas_n
);
  import palette_pwr_pkg::*;

  st_t s;
  st_t n;

  logic       suspended;
  logic       act_edge;
  logic       ref_edge;
  logic       activity;
  logic       req;
  logic       accept;
  logic       allowed;
  logic       active;
  logic       refresh_on;
  logic       tmr_hit;
  logic [7:0] lut_idx;
  rgb_t       entry;
  rgb_t       rd_entry;
  logic [7:0] ext_rd;
  logic [7:0] rd_mux;
  logic [7:0] wd;

  always_comb begin
    n = s;
    wd = avs_writedata[7:0];
    suspended = (s.mode == MODE_SUSPEND);

    // Only the second and third flops feed the edge detectors
    n.act_sync = {s.act_sync[1:0], sleep_activity_clock};
    n.ref_sync = {s.ref_sync[1:0], slow_refresh_clk};
    act_edge = s.act_sync[2] ^ s.act_sync[1];
    ref_edge = s.ref_sync[2] ^ s.ref_sync[1];

    n.vmem_gnt = vmem_req & ~suspended;                            // [R12] [R13] [R17]
    activity = act_edge | (vmem_req & ~suspended);                 // [R14] [R16]

    // Extension data read mux
    case (s.ext_idx)
      EXT_PWR_CTRL: ext_rd = {4'h0, s.pwr_ctrl};                   // [R20]
      EXT_TIMEOUT:  ext_rd = {2'h0, s.timeout};
      EXT_CUR_COL:  ext_rd = s.cur_col;
      EXT_CUR_ROW:  ext_rd = s.cur_row;
      EXT_STATUS:   ext_rd = {1'b0, s.mode, s.pnl};
      default:      ext_rd = 8'h00;
    endcase

    rd_entry = s.palette[s.rd_idx];
    case (avs_address)
      OFS_PIX_MASK: rd_mux = s.pix_mask;
      OFS_RD_ADDR:  rd_mux = s.rd_idx;
      OFS_WR_ADDR:  rd_mux = s.wr_idx;
      OFS_PAL_DATA: begin
        case (s.rd_phase) // [R3]
          2'h0:    rd_mux = {2'h0, rd_entry.red};
          2'h1:    rd_mux = {2'h0, rd_entry.green};
          default: rd_mux = {2'h0, rd_entry.blue};
        endcase
      end
      OFS_EXT_IDX:  rd_mux = s.ext_idx;
      OFS_EXT_DATA: rd_mux = ext_rd; // [R22]
      OFS_STATUS:   rd_mux = {s.wr_phase, s.rd_phase, s.pnl};
      default:      rd_mux = 8'h00;
    endcase

    // One wait cycle per access; the access acts on the edge that sees waitrequest low
    req = avs_read | avs_write;
    accept = req & ~s.waitreq;
    n.waitreq = ~(req & s.waitreq);
    // In suspend only the extension pair stays open, so software can leave it
    allowed = ~suspended | (avs_address == OFS_EXT_IDX) | (avs_address == OFS_EXT_DATA);   // [R17] [R19]
    if (req & s.waitreq) begin
      n.rdata = allowed ? rd_mux : 8'h00; // [R10]
    end

    n.mirror.valid = 1'b0;
    if (accept & avs_write & allowed) begin
      case (avs_address)
        OFS_PIX_MASK: n.pix_mask = wd; // [R9]
        OFS_RD_ADDR: begin
          n.rd_idx = wd; // [R3]
          n.rd_phase = 2'h0; // [R4]
          n.wr_phase = 2'h0; // [R4]
        end
        OFS_WR_ADDR: begin
          n.wr_idx = wd; // [R1]
          n.rd_phase = 2'h0; // [R4]
          n.wr_phase = 2'h0; // [R4]
        end
        OFS_PAL_DATA: begin
          case (s.wr_phase) // [R1]
            2'h0: begin
              n.wr_red = wd[5:0];
              n.wr_phase = 2'h1;
            end
            2'h1: begin
              n.wr_green = wd[5:0];
              n.wr_phase = 2'h2;
            end
            default: begin
              n.palette[s.wr_idx] = '{s.wr_red, s.wr_green, wd[5:0]}; // [R2] [R5]
              n.mirror = '{1'b1, s.wr_idx, '{s.wr_red, s.wr_green, wd[5:0]}}; // [R21]
              n.wr_idx = s.wr_idx + 8'h01; // [R2]
              n.wr_phase = 2'h0;
            end
          endcase
        end
        OFS_EXT_IDX: n.ext_idx = wd; // [R22]
        OFS_EXT_DATA: begin
          case (s.ext_idx) // [R22]
            EXT_PWR_CTRL: n.pwr_ctrl = wd[3:0];
            EXT_TIMEOUT:  n.timeout = wd[5:0]; // [R15]
            EXT_CUR_COL:  n.cur_col = wd;
            EXT_CUR_ROW:  n.cur_row = wd;
            default:      n.ext_idx = s.ext_idx;
          endcase
        end
        default: n.ext_idx = s.ext_idx;
      endcase
    end
    if (accept & avs_read & allowed & (avs_address == OFS_PAL_DATA)) begin
      if (s.rd_phase == 2'h2) begin
        n.rd_phase = 2'h0;
        n.rd_idx = s.rd_idx + 8'h01;                               // [R3]
      end else begin
        n.rd_phase = s.rd_phase + 2'h1;
      end
    end

    // Power-save timer: seconds prescaler, then minutes, saturating at 63
    tmr_hit = s.pwr_ctrl[PWR_TMR_EN] & (s.timeout != 6'h00) & (s.min_cnt >= s.timeout);  // [R15] [R23]
    if (activity | ~s.pwr_ctrl[PWR_TMR_EN] | (s.mode != MODE_NORMAL)) begin
      n.sec_cnt = 32'h0000_0000;                                   // [R16]
      n.sec_in_min = 6'h00;
      n.min_cnt = 6'h00;
    end else if (s.sec_cnt == 32'(CYC_PER_SEC - 1)) begin
      n.sec_cnt = 32'h0000_0000;
      if (s.sec_in_min == 6'(SEC_PER_MIN - 1)) begin
        n.sec_in_min = 6'h00;
        n.min_cnt = (s.min_cnt == 6'h3f) ? s.min_cnt : s.min_cnt + 6'h01;   // [R23]
      end else begin
        n.sec_in_min = s.sec_in_min + 6'h01;
      end
    end else begin
      n.sec_cnt = s.sec_cnt + 32'h0000_0001;
    end

    // Mode machine; suspend follows the software bit only
    case (s.mode)
      MODE_NORMAL: begin
        if (s.pwr_ctrl[PWR_SUSPEND]) begin
          n.mode = MODE_SUSPEND;                                   // [R19]
        end else if (s.pwr_ctrl[PWR_SB_REQ] | tmr_hit) begin
          n.mode = MODE_STANDBY;                                   // [R15]
          n.pwr_ctrl[PWR_SB_REQ] = 1'b0;
        end
      end
      MODE_STANDBY: begin
        if (s.pwr_ctrl[PWR_SUSPEND]) begin
          n.mode = MODE_SUSPEND;                                   // [R19]
        end else if (activity & (s.pnl == PNL_OFF)) begin
          n.mode = MODE_NORMAL;                                    // [R14]
        end
      end
      MODE_SUSPEND: begin
        if (~s.pwr_ctrl[PWR_SUSPEND] & (s.pnl == PNL_OFF)) begin
          n.mode = MODE_NORMAL;                                    // [R19]
        end
      end
      default: n.mode = MODE_NORMAL;
    endcase

    // Panel power sequencing; a sequence once begun always runs to its end
    case (s.pnl)
      PNL_OFF: begin
        n.pnl_cnt = 12'h000;
        if (s.mode == MODE_NORMAL) begin
          n.pnl = PNL_UP;                                          // [R12]
        end
      end
      PNL_UP: begin
        n.pnl_cnt = s.pnl_cnt + 12'h001;
        if (s.pnl_cnt == 12'(PANEL_STEP_CYC - 1)) begin
          n.pnl = PNL_ON;
          n.pnl_cnt = 12'h000;
        end
      end
      PNL_ON: begin
        if (s.mode != MODE_NORMAL) begin
          n.pnl = PNL_DOWN;                                        // [R13] [R17]
        end
      end
      PNL_DOWN: begin
        n.pnl_cnt = s.pnl_cnt + 12'h001;
        if (s.pnl_cnt == 12'(PANEL_STEP_CYC - 1)) begin
          n.pnl = PNL_OFF;                                         // [R14]
          n.pnl_cnt = 12'h000;
        end
      end
      default: n.pnl = PNL_OFF;
    endcase

    // Video DRAM refresh: CAS-before-RAS normally, slow-clock RAS in suspend
    if (suspended) begin
      n.refr_cnt = 12'h000;
      n.cas_n = 1'b0;                                              // [R18]
      n.ras_n = ~ref_edge;                                         // [R18]
    end else if (s.refr_cnt == 12'(REFRESH_CYC - 1)) begin
      n.refr_cnt = 12'h000;
      n.cas_n = 1'b0;                                              // [R12] [R13]
      n.ras_n = 1'b1;
    end else begin
      n.refr_cnt = s.refr_cnt + 12'h001;
      // RAS follows the single CAS cycle, then both rest high until the next slot
      n.ras_n = s.cas_n;
      n.cas_n = 1'b1;
    end

    // Screen timing; frozen outside normal mode so no panel refresh runs
    refresh_on = (s.mode == MODE_NORMAL) & (s.pnl == PNL_ON);      // [R12] [R13]
    active = refresh_on & (s.h_cnt < H_ACTIVE) & (s.v_cnt < V_ACTIVE);
    if (~refresh_on) begin
      n.h_cnt = 10'h000;
      n.v_cnt = 10'h000;
    end else if (s.h_cnt == H_LAST) begin
      n.h_cnt = 10'h000;
      n.v_cnt = (s.v_cnt == V_LAST) ? 10'h000 : s.v_cnt + 10'h001;
      if (s.v_cnt == V_LAST) begin
        n.frame_cnt = s.frame_cnt + 4'h1;
      end
    end else begin
      n.h_cnt = s.h_cnt + 10'h001;
    end
    n.scan.hsync = refresh_on & (s.h_cnt >= H_SYNC_B) & (s.h_cnt < H_SYNC_E);   // [R7]
    n.scan.vsync = refresh_on & (s.v_cnt >= V_SYNC_B) & (s.v_cnt < V_SYNC_E);   // [R7]
    n.scan.blank = ~active;                                        // [R7]
    n.scan.disp_en = active;                                       // [R7]
    n.scan.cursor_hit = active & (s.h_cnt[9:3] == s.cur_col[6:0])
                        & (s.v_cnt[9:1] == {1'b0, s.cur_row});     // [R7]

    // Lookup uses its own read port, so host traffic never stalls a pixel
    lut_idx = {4'h0, pixel_idx} & s.pix_mask;                      // [R6] [R9]
    entry = s.palette[lut_idx];                                    // [R5] [R10]
    n.rgb = active ? entry : '0;                                   // [R6]
    n.lcd_upper = active ? fa_data : 4'h0;                         // [R8]
    n.lcd_lower = active ? vm_data : 4'h0;                         // [R8]
    if (~active) begin
      n.lcd_frc = 3'h0;
    end else if (s.pwr_ctrl[PWR_COLOUR]) begin
      n.lcd_frc = {entry.red[5:3] > s.frame_cnt[2:0],
                   entry.green[5:3] > s.frame_cnt[2:0],
                   entry.blue[5:4] > s.frame_cnt[1:0]};            // [R11]
    end else begin
      n.lcd_frc = {3{entry.green[5:2] > s.frame_cnt}};             // [R11]
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.pix_mask <= PIX_MASK_RST;
      s.timeout <= TIMEOUT_RST;
      s.waitreq <= 1'b1;
      s.mode <= MODE_NORMAL;
      s.pnl <= PNL_OFF;
      s.ras_n <= 1'b1;
      s.cas_n <= 1'b1;
      s.scan.blank <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata    = {24'h00_0000, s.rdata};
  assign avs_waitrequest = s.waitreq;
  assign vmem_gnt        = s.vmem_gnt;
  assign rgb_out         = s.rgb;
  assign scan_out        = s.scan;
  assign lcd_upper       = s.lcd_upper;
  assign lcd_lower       = s.lcd_lower;
  assign lcd_frc         = s.lcd_frc;
  assign pal_mirror      = s.mirror;
  assign panel_pwr_on    = (s.pnl == PNL_UP) | (s.pnl == PNL_ON);  // Decoded from one-hot flops
  assign synth_pwr_on    = ~s.mode[2];                             // [R13] [R17]
  assign dram_ras_n      = s.ras_n;
  assign dram_cas_n      = s.cas_n;

endmodule

// ### shared/palette_pwr_pkg.sv
// Constants, encodings and carrier types of the palette and display power controller.
// Assumes one 125 MHz core clock and an Avalon-MM master with waitrequest.
package palette_pwr_pkg;

  // Byte addresses of the register words
  localparam logic [4:0] OFS_PIX_MASK = 5'h00;
  localparam logic [4:0] OFS_RD_ADDR  = 5'h04;
  localparam logic [4:0] OFS_WR_ADDR  = 5'h08;
  localparam logic [4:0] OFS_PAL_DATA = 5'h0c;
  localparam logic [4:0] OFS_EXT_IDX  = 5'h10;
  localparam logic [4:0] OFS_EXT_DATA = 5'h14;
  localparam logic [4:0] OFS_STATUS   = 5'h18;

  // Extension register indices
  localparam logic [7:0] EXT_PWR_CTRL = 8'h00;
  localparam logic [7:0] EXT_TIMEOUT  = 8'h01;
  localparam logic [7:0] EXT_CUR_COL  = 8'h02;
  localparam logic [7:0] EXT_CUR_ROW  = 8'h03;
  localparam logic [7:0] EXT_STATUS   = 8'h04;

  // Power control bit positions
  localparam int PWR_SUSPEND = 0;
  localparam int PWR_TMR_EN  = 1;
  localparam int PWR_SB_REQ  = 2;
  localparam int PWR_COLOUR  = 3;

  // Values after reset
  localparam logic [7:0] PIX_MASK_RST = 8'hff;
  localparam logic [5:0] TIMEOUT_RST  = 6'h00;

  // Screen timing, 640 x 480
  localparam logic [9:0] H_ACTIVE = 10'h280;
  localparam logic [9:0] H_SYNC_B = 10'h290;
  localparam logic [9:0] H_SYNC_E = 10'h2f0;
  localparam logic [9:0] H_LAST   = 10'h31f;
  localparam logic [9:0] V_ACTIVE = 10'h1e0;
  localparam logic [9:0] V_SYNC_B = 10'h1ea;
  localparam logic [9:0] V_SYNC_E = 10'h1ec;
  localparam logic [9:0] V_LAST   = 10'h20c;

  // Times and derived cycle counts at 125 MHz
  localparam int CLK_MHZ         = 125;
  localparam int SEC_PER_MIN     = 60;
  localparam int REFRESH_US      = 15;
  localparam int PANEL_STEP_US   = 20;
  localparam int REFRESH_CYC     = REFRESH_US * CLK_MHZ;
  localparam int PANEL_STEP_CYC  = PANEL_STEP_US * CLK_MHZ;

  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b001,
    MODE_STANDBY = 3'b010,
    MODE_SUSPEND = 3'b100
  } mode_t;

  typedef enum logic [3:0] {
    PNL_OFF  = 4'b0001,
    PNL_UP   = 4'b0010,
    PNL_ON   = 4'b0100,
    PNL_DOWN = 4'b1000
  } pnl_t;

  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } rgb_t;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic blank;
    logic disp_en;
    logic cursor_hit;
  } scan_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] index;
    rgb_t       color;
  } mirror_t;

  typedef struct packed {
    rgb_t [255:0] palette;
    logic [7:0]   pix_mask;
    logic [7:0]   rd_idx;
    logic [7:0]   wr_idx;
    logic [1:0]   rd_phase;
    logic [1:0]   wr_phase;
    logic [5:0]   wr_red;
    logic [5:0]   wr_green;
    logic [7:0]   ext_idx;
    logic [3:0]   pwr_ctrl;
    logic [5:0]   timeout;
    logic [7:0]   cur_col;
    logic [7:0]   cur_row;
    logic         waitreq;
    logic [7:0]   rdata;
    mode_t        mode;
    pnl_t         pnl;
    logic [11:0]  pnl_cnt;
    logic [31:0]  sec_cnt;
    logic [5:0]   sec_in_min;
    logic [5:0]   min_cnt;
    logic [2:0]   act_sync;
    logic [2:0]   ref_sync;
    logic [11:0]  refr_cnt;
    logic         ras_n;
    logic         cas_n;
    logic [9:0]   h_cnt;
    logic [9:0]   v_cnt;
    logic [3:0]   frame_cnt;
    rgb_t         rgb;
    scan_t        scan;
    logic [3:0]   lcd_upper;
    logic [3:0]   lcd_lower;
    logic [2:0]   lcd_frc;
    mirror_t      mirror;
    logic         vmem_gnt;
  } st_t;

endpackage

// ### sim/pal_far_model.sv
// Far-side model: pixel fetch source and the two activity pins.
// Pins stand still until the bench asks for edges.
`timescale 1ns/1ps
module pal_far_model (
  // Clock and bench control
  input  wire logic [3:0] pix,
  input  wire logic       core_clk,
  // Data and pins into the block
  output logic [3:0]      pixel_idx,
  output logic [3:0]      fa_data,
  output logic [3:0]      vm_data,
  output logic            sleep_activity_clock,
  output logic            slow_refresh_clk
);
  // Distinct halves so a swapped panel bus shows
  assign pixel_idx = pix;
  assign fa_data   = 4'h5;
  assign vm_data   = 4'ha;
  initial begin
    sleep_activity_clock = 1'b0;
    slow_refresh_clk     = 1'b0;
  end
  // Edges a few cycles apart; the toggle is last so the bench sees its effect
  task automatic kick(input logic slow, input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      if (slow) begin
        slow_refresh_clk <= ~slow_refresh_clk;
      end else begin
        sleep_activity_clock <= ~sleep_activity_clock;
      end
    end
  endtask
endmodule

// ### sim/palette_and_display_power_ctrl_tb.sv
// Self-checking bench: Avalon master tasks plus the far-side model.
// One minute is shortened to 60 x 4 cycles.
`timescale 1ns/1ps
module palette_and_display_power_ctrl_tb;
  import palette_pwr_pkg::*;
  logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest, vmem_req, vmem_gnt;
  logic sleep_activity_clock, slow_refresh_clk, panel_pwr_on, synth_pwr_on, dram_ras_n, dram_cas_n;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [3:0]  pix, pixel_idx, fa_data, vm_data, lcd_upper, lcd_lower;
  logic [7:0]  q;
  rgb_t        rgb_out;
  scan_t       scan_out;
  mirror_t     pal_mirror;
  mirror_t     mir_q;
  int          num_errors;
  int          n_checks;

  palette_and_display_power_ctrl #(.CYC_PER_SEC(4)) palette_and_display_power_ctrl_i (
    .core_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .vmem_req, .vmem_gnt, .pixel_idx, .fa_data, .vm_data, .sleep_activity_clock,
    .slow_refresh_clk, .rgb_out, .scan_out, .lcd_upper, .lcd_lower, .lcd_frc(), .pal_mirror,
    .panel_pwr_on, .synth_pwr_on, .dram_ras_n, .dram_cas_n);
  pal_far_model pal_far_model_i (
    .pix, .core_clk, .pixel_idx, .fa_data, .vm_data, .sleep_activity_clock, .slow_refresh_clk);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Mirror pulse lasts one cycle, so keep the last one
  always @(posedge core_clk) if (pal_mirror.valid === 1'b1) mir_q <= pal_mirror;

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chkb(input string s, input logic e, input logic g);
    chk(s, {31'h0, e}, {31'h0, g});
  endtask
  // One bus access; request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= w;
    avs_read      <= !w;
    n = 0;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chkb("waitrequest", 1'b0, avs_waitrequest);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string s);
    acc(1'b0, a, 8'h0);
    chk(s, {24'h0, e}, {24'h0, q});
  endtask
  task automatic xw(input logic [7:0] i, input logic [7:0] d);
    wr(OFS_EXT_IDX, i);
    wr(OFS_EXT_DATA, d);
  endtask
  task automatic rgb3(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    wr(OFS_PAL_DATA, r);
    wr(OFS_PAL_DATA, g);
    wr(OFS_PAL_DATA, b);
  endtask
  // Poll mode and panel state; panel steps take thousands of cycles
  task automatic wait_st(input logic [7:0] e);
    int n;
    wr(OFS_EXT_IDX, EXT_STATUS);
    n = 0;
    do begin
      acc(1'b0, OFS_EXT_DATA, 8'h0);
      n++;
    end while (q !== e && n < 3000);
    chk("ext status", {24'h0, e}, {24'h0, q});
  endtask
  task automatic see_px();
    int n;
    for (n = 0; n < 2000 && scan_out.disp_en !== 1'b1; n++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask

  task automatic t_reset();
    @(posedge core_clk);
    chkb("synth", 1'b1, synth_pwr_on);
    chkb("panel", 1'b1, panel_pwr_on);
    rd(OFS_PIX_MASK, PIX_MASK_RST, "mask");
    xw(EXT_TIMEOUT, 8'h2a);
    rd(OFS_EXT_DATA, 8'h2a, "timeout");
    xw(EXT_CUR_COL, 8'h15);
    rd(OFS_EXT_DATA, 8'h15, "cursor");
    rd(5'h1c, 8'h00, "unmapped");
    $display("Test reset done");
  endtask
  task automatic t_palette();
    wr(OFS_WR_ADDR, 8'h05);
    wr(OFS_PAL_DATA, 8'h01);
    wr(OFS_PAL_DATA, 8'h02);
    wr(OFS_WR_ADDR, 8'h0a);
    rgb3(8'h11, 8'h22, 8'h33);
    rd(OFS_WR_ADDR, 8'h0b, "write index");
    chk("mirror", {5'h0, 1'b1, 8'h0a, 6'h11, 6'h22, 6'h33}, {5'h0, mir_q});
    wr(OFS_WR_ADDR, 8'h03);
    rgb3(8'hff, 8'h2a, 8'h15);
    wr(OFS_WR_ADDR, 8'hff);
    rgb3(8'h01, 8'h01, 8'h01);
    rd(OFS_WR_ADDR, 8'h00, "index wrap");
    wr(OFS_RD_ADDR, 8'h0a);
    rd(OFS_PAL_DATA, 8'h11, "red");
    rd(OFS_PAL_DATA, 8'h22, "green");
    wr(OFS_RD_ADDR, 8'h03);
    rd(OFS_PAL_DATA, 8'h3f, "red 6 bit");
    rd(OFS_PAL_DATA, 8'h2a, "green");
    rd(OFS_PAL_DATA, 8'h15, "blue");
    rd(OFS_RD_ADDR, 8'h04, "read index");
    $display("Test palette done");
  endtask
  task automatic t_pixel();
    pix <= 4'h3;
    wait_st(8'h14);
    see_px();
    chk("rgb", {14'h0, 6'h3f, 6'h2a, 6'h15}, {14'h0, rgb_out});
    chk("panel data", 32'h5a, {24'h0, lcd_upper, lcd_lower});
    wr(OFS_PIX_MASK, 8'h00);
    see_px();
    chk("masked rgb", 32'h0, {14'h0, rgb_out});
    wr(OFS_PIX_MASK, 8'hff);
    $display("Test pixel done");
  endtask
  task automatic t_standby();
    xw(EXT_PWR_CTRL, 8'h04);
    pal_far_model_i.kick(1'b0, 2);
    wait_st(8'h21);
    chkb("synth standby", 1'b1, synth_pwr_on);
    rd(OFS_EXT_DATA, 8'h21, "stays standby");
    rd(OFS_PIX_MASK, 8'hff, "mask standby");
    pal_far_model_i.kick(1'b0, 2);
    wait_st(8'h14);
    $display("Test standby done");
  endtask
  task automatic t_timer();
    int n;
    xw(EXT_TIMEOUT, 8'h01);
    xw(EXT_PWR_CTRL, 8'h02);
    for (n = 0; n < 4; n++) begin
      repeat (150) @(posedge core_clk);
      vmem_req <= 1'b1;
      @(posedge core_clk);
      vmem_req <= 1'b0;
      @(posedge core_clk);
      chkb("grant", 1'b1, vmem_gnt);
    end
    wait_st(8'h14);
    for (n = 0; n < 400 && panel_pwr_on === 1'b1; n++) @(posedge core_clk);
    chkb("timer standby", 1'b0, panel_pwr_on);
    xw(EXT_PWR_CTRL, 8'h00);
    wait_st(8'h21);
    pal_far_model_i.kick(1'b0, 2);
    wait_st(8'h14);
    $display("Test timer done");
  endtask
  task automatic t_suspend();
    int k;
    int n;
    xw(EXT_PWR_CTRL, 8'h01);
    wait_st(8'h41);
    chkb("synth off", 1'b0, synth_pwr_on);
    rd(OFS_PIX_MASK, 8'h00, "mask refused");
    vmem_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    chkb("no grant", 1'b0, vmem_gnt);
    vmem_req <= 1'b0;
    chkb("cas low", 1'b0, dram_cas_n);
    for (k = 0; k < 2; k++) begin
      pal_far_model_i.kick(1'b1, 1);
      for (n = 0; n < 40 && dram_ras_n !== 1'b0; n++) @(posedge core_clk);
      chkb("ras pulse", 1'b0, dram_ras_n);
    end
    pal_far_model_i.kick(1'b0, 2);
    rd(OFS_EXT_DATA, 8'h41, "held in suspend");
    xw(EXT_PWR_CTRL, 8'h00);
    wait_st(8'h14);
    $display("Test suspend done");
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Longest path is about seven panel steps plus polling
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    $display("ERROR watchdog expected end seen timeout");
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    vmem_req = 1'b0;
    pix = 4'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_palette();
    t_pixel();
    t_standby();
    t_timer();
    t_suspend();
    stop_test();
  end
endmodule

// ### sim/palette_pwr_asserts.sv
// Port checker for the palette and display power controller.
// Bound to the design top; sees its ports only.
`timescale 1ns/1ps
module palette_pwr_asserts (
  // Clock, reset and bus
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  input wire logic [4:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // Memory request and outputs watched
  input wire logic                    vmem_req,
  input wire logic                    vmem_gnt,
  input wire palette_pwr_pkg::rgb_t   rgb_out,
  input wire palette_pwr_pkg::scan_t  scan_out,
  input wire logic [3:0]              lcd_upper,
  input wire logic [3:0]              lcd_lower,
  input wire palette_pwr_pkg::mirror_t pal_mirror,
  input wire logic                    synth_pwr_on,
  input wire logic                    dram_ras_n,
  input wire logic                    dram_cas_n
);
  import palette_pwr_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_hi; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("readdata upper bits set");
  property p_gnt; vmem_gnt |-> $past(vmem_req); endproperty
  a_gnt: assert property (p_gnt) else $error("grant without request");
  property p_sus; !synth_pwr_on && $past(!synth_pwr_on) |-> !vmem_gnt && !dram_cas_n; endproperty
  a_sus: assert property (p_sus) else $error("suspend access or cas");
  property p_ras; $fell(dram_ras_n) |=> dram_ras_n; endproperty
  a_ras: assert property (p_ras) else $error("ras pulse too long");
  property p_blank; scan_out.blank |-> rgb_out == '0 && lcd_upper == 4'h0 && lcd_lower == 4'h0; endproperty
  a_blank: assert property (p_blank) else $error("data while blanked");
  property p_hs; $rose(scan_out.hsync) |-> ##95 scan_out.hsync ##1 !scan_out.hsync; endproperty
  a_hs: assert property (p_hs) else $error("hsync width");
  property p_mir;
    pal_mirror.valid |-> $past(avs_write && !avs_waitrequest && avs_address == OFS_PAL_DATA);
  endproperty
  a_mir: assert property (p_mir) else $error("mirror without blue write");
endmodule
bind palette_and_display_power_ctrl palette_pwr_asserts palette_pwr_asserts_i (
  .core_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .vmem_req, .vmem_gnt, .rgb_out, .scan_out, .lcd_upper, .lcd_lower, .pal_mirror,
  .synth_pwr_on, .dram_ras_n, .dram_cas_n);
